// *** pdma_channel_regs.sv ***
// Purpose: AHB-Lite register interface and channel control of a peripheral DMA channel pair
// Assumes: Single-word transfers; request pulses from same-clock logic
// Notes:   Zero wait states; mode register selects half duplex and item size
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`include "pdma_defs.svh"
module pdma_channel_regs
    import pdma_pkg::*;
(
    input  wire logic        clk,          // System clock
    input  wire logic        arst_n,       // Async reset, low
    input  wire logic        hsel,         // Slave select
    input  wire logic [11:0] haddr,        // Byte address
    input  wire logic [1:0]  htrans,       // Transfer type
    input  wire logic        hwrite,       // Write
    input  wire logic [2:0]  hsize,        // Transfer size
    input  wire logic        hready,       // Bus ready in
    input  wire logic [31:0] hwdata,       // Write data
    output logic [31:0]      hrdata,       // Read data
    output logic             hreadyout,    // Ready out
    output logic             hresp,        // Response, always OKAY
    input  wire logic        rxItemDone,   // Receive item moved
    input  wire logic        txItemDone,   // Transmit item moved
    output logic             rxRequest,    // Receive channel may request
    output logic             txRequest,    // Transmit channel may request
    output logic [31:0]      rxAddress,    // Receive memory address
    output logic [31:0]      txAddress,    // Transmit memory address
    output logic             rxTransferEnd,   // Receive end flag
    output logic             rxBuffersFull,   // Receive full flag
    output logic             txTransferEnd,   // Transmit end flag
    output logic             txBuffersEmpty   // Transmit empty flag
);
    import pdma_pkg::*;

    logic        wrPend_reg;
    logic [11:0] wrAddr_reg;
    logic        rxEn_reg;
    logic        txEn_reg;
    logic        halfDuplex_reg;
    pdma_size_t  itemSize_reg;
    logic [2:0]  stepBytes;
    logic        ctrlWr;
    logic [31:0] rdNext;
    logic        addrPhase;
    logic [3:0]  fRx_reg;
    logic        rxEndSet;
    logic        rxBufSet;
    logic        txEndSet;
    logic        txBufSet;
    logic        rxActive;
    logic        txActive;
    logic [31:0] rxCurPtr;
    logic [15:0] rxCurCnt;
    logic [31:0] rxNxtPtr;
    logic [15:0] rxNxtCnt;
    logic [31:0] txCurPtr;
    logic [15:0] txCurCnt;
    logic [31:0] txNxtPtr;
    logic [15:0] txNxtCnt;
    logic        wRxCp;
    logic        wRxCc;
    logic        wRxNp;
    logic        wRxNc;
    logic        wTxCp;
    logic        wTxCc;
    logic        wTxNp;
    logic        wTxNc;
    logic        hdItem;
    logic        rxCntNonzeroWr;
    logic        txCntNonzeroWr;

    // Address phase capture; writes land in the data phase
    assign addrPhase = hsel && hready && htrans[1];
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 12'h000;
        end
        else
        begin
            wrPend_reg <= addrPhase && hwrite;
            wrAddr_reg <= haddr;
        end
    end

    // Write strobes; in half duplex one store serves both directions
    always_comb
    begin
        wRxCp = 1'b0;
        wRxCc = 1'b0;
        wRxNp = 1'b0;
        wRxNc = 1'b0;
        wTxCp = 1'b0;
        wTxCc = 1'b0;
        wTxNp = 1'b0;
        wTxNc = 1'b0;
        ctrlWr = 1'b0;
        if (!wrPend_reg)
            ctrlWr = 1'b0;
        else if (wrAddr_reg == `PDMA_OFF_RX_CUR_PTR)
            wRxCp = 1'b1;
        else if (wrAddr_reg == `PDMA_OFF_RX_CUR_CNT)
            wRxCc = 1'b1;
        else if (wrAddr_reg == `PDMA_OFF_TX_CUR_PTR)
            wTxCp = 1'b1;
        else if (wrAddr_reg == `PDMA_OFF_TX_CUR_CNT)
            wTxCc = 1'b1;
        else if (wrAddr_reg == `PDMA_OFF_RX_NXT_PTR)
            wRxNp = 1'b1;
        else if (wrAddr_reg == `PDMA_OFF_RX_NXT_CNT)
            wRxNc = 1'b1;
        else if (wrAddr_reg == `PDMA_OFF_TX_NXT_PTR)
            wTxNp = 1'b1;
        else if (wrAddr_reg == `PDMA_OFF_TX_NXT_CNT)
            wTxNc = 1'b1;
        else if (wrAddr_reg == `PDMA_OFF_CTRL)
            ctrlWr = 1'b1;
        if (halfDuplex_reg)
        begin
            // Fold transmit writes onto the shared receive-side store
            wRxCp = wRxCp | wTxCp;
            wRxCc = wRxCc | wTxCc;
            wRxNp = wRxNp | wTxNp;
            wRxNc = wRxNc | wTxNc;
            wTxCp = 1'b0;
            wTxCc = 1'b0;
            wTxNp = 1'b0;
            wTxNc = 1'b0;
        end
    end

    // Mode register: half duplex and item size
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            halfDuplex_reg <= 1'b0;
            itemSize_reg   <= PDMA_SZ_BYTE;
        end
        else if (wrPend_reg && wrAddr_reg == `PDMA_OFF_MODE)
        begin
            halfDuplex_reg <= hwdata[`PDMA_BIT_HALF_DUPLEX];
            itemSize_reg   <= pdma_size_t'(hwdata[`PDMA_BIT_SIZE_HI:`PDMA_BIT_SIZE_LO]);
        end
    end

    // Receive enable state; disable dominates
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rxEn_reg <= 1'b0;
        else if (ctrlWr && hwdata[`PDMA_BIT_RX_DIS])
            rxEn_reg <= 1'b0;
        else if (ctrlWr && halfDuplex_reg && hwdata[`PDMA_BIT_TX_DIS])
            rxEn_reg <= 1'b0;
        else if (ctrlWr && halfDuplex_reg && hwdata[`PDMA_BIT_TX_EN])
            rxEn_reg <= hwdata[`PDMA_BIT_RX_EN] ? 1'b1 : 1'b0;
        else if (ctrlWr && hwdata[`PDMA_BIT_RX_EN])
            rxEn_reg <= 1'b1;
    end

    // Transmit enable state; disable dominates, half duplex couples directions
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            txEn_reg <= 1'b0;
        else if (ctrlWr && hwdata[`PDMA_BIT_TX_DIS])
            txEn_reg <= 1'b0;
        else if (ctrlWr && halfDuplex_reg && hwdata[`PDMA_BIT_RX_DIS])
            txEn_reg <= 1'b0;
        else if (ctrlWr && halfDuplex_reg && hwdata[`PDMA_BIT_RX_EN])
            txEn_reg <= 1'b0;
        else if (ctrlWr && hwdata[`PDMA_BIT_TX_EN])
            txEn_reg <= 1'b1;
    end

    // Item size to pointer step
    pdma_step uStep
    (
        .itemSize  (itemSize_reg),
        .stepBytes (stepBytes)
    );

    // In half duplex the receive store follows whichever direction is enabled
    assign hdItem = halfDuplex_reg ? (rxItemDone | txItemDone) : rxItemDone;

    pdma_dir uRx
    (
        .clk       (clk),
        .arst_n    (arst_n),
        .enable    (halfDuplex_reg ? (rxEn_reg | txEn_reg) : rxEn_reg),
        .itemDone  (hdItem),
        .stepBytes (stepBytes),
        .wrCurPtr  (wRxCp),
        .wrCurCnt  (wRxCc),
        .wrNxtPtr  (wRxNp),
        .wrNxtCnt  (wRxNc),
        .wrData    (hwdata),
        .curPtr    (rxCurPtr),
        .curCnt    (rxCurCnt),
        .nxtPtr    (rxNxtPtr),
        .nxtCnt    (rxNxtCnt),
        .active    (rxActive),
        .endSet    (rxEndSet),
        .bufSet    (rxBufSet)
    );

    pdma_dir uTx
    (
        .clk       (clk),
        .arst_n    (arst_n),
        .enable    (txEn_reg && !halfDuplex_reg),
        .itemDone  (txItemDone),
        .stepBytes (stepBytes),
        .wrCurPtr  (wTxCp),
        .wrCurCnt  (wTxCc),
        .wrNxtPtr  (wTxNp),
        .wrNxtCnt  (wTxNc),
        .wrData    (hwdata),
        .curPtr    (txCurPtr),
        .curCnt    (txCurCnt),
        .nxtPtr    (txNxtPtr),
        .nxtCnt    (txNxtCnt),
        .active    (txActive),
        .endSet    (txEndSet),
        .bufSet    (txBufSet)
    );

    // Nonzero count writes clear the end flags
    assign rxCntNonzeroWr = (wRxCc || wRxNc) && (hwdata[15:0] != 16'h0000);
    assign txCntNonzeroWr = halfDuplex_reg ? rxCntNonzeroWr
                          : ((wTxCc || wTxNc) && (hwdata[15:0] != 16'h0000));

    // Sticky end flags; a set in the clearing cycle wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            fRx_reg <= 4'h0;
        else
        begin
            fRx_reg[0] <= (halfDuplex_reg ? (rxEndSet && rxEn_reg) : rxEndSet)
                          || (fRx_reg[0] && !rxCntNonzeroWr);
            fRx_reg[1] <= (halfDuplex_reg ? (rxBufSet && rxEn_reg) : rxBufSet)
                          || (fRx_reg[1] && !txCntNonzeroWr);
            fRx_reg[2] <= (halfDuplex_reg ? (rxEndSet && txEn_reg) : txEndSet)
                          || (fRx_reg[2] && !txCntNonzeroWr);
            fRx_reg[3] <= (halfDuplex_reg ? (rxBufSet && txEn_reg) : txBufSet)
                          || (fRx_reg[3] && !txCntNonzeroWr);
        end
    end

    // Read mux; unmapped and write-only offsets read zero
    always_comb
    begin
        rdNext = 32'h00000000;
        if (haddr == `PDMA_OFF_RX_CUR_PTR || (halfDuplex_reg && haddr == `PDMA_OFF_TX_CUR_PTR))
            rdNext = rxCurPtr;
        else if (haddr == `PDMA_OFF_RX_CUR_CNT || (halfDuplex_reg && haddr == `PDMA_OFF_TX_CUR_CNT))
            rdNext = {16'h0000, rxCurCnt};
        else if (haddr == `PDMA_OFF_RX_NXT_PTR || (halfDuplex_reg && haddr == `PDMA_OFF_TX_NXT_PTR))
            rdNext = rxNxtPtr;
        else if (haddr == `PDMA_OFF_RX_NXT_CNT || (halfDuplex_reg && haddr == `PDMA_OFF_TX_NXT_CNT))
            rdNext = {16'h0000, rxNxtCnt};
        else if (haddr == `PDMA_OFF_TX_CUR_PTR)
            rdNext = txCurPtr;
        else if (haddr == `PDMA_OFF_TX_CUR_CNT)
            rdNext = {16'h0000, txCurCnt};
        else if (haddr == `PDMA_OFF_TX_NXT_PTR)
            rdNext = txNxtPtr;
        else if (haddr == `PDMA_OFF_TX_NXT_CNT)
            rdNext = {16'h0000, txNxtCnt};
        else if (haddr == `PDMA_OFF_STATUS)
        begin
            rdNext[`PDMA_BIT_RX_EN] = rxEn_reg;
            rdNext[`PDMA_BIT_TX_EN] = txEn_reg;
        end
        else if (haddr == `PDMA_OFF_MODE)
            rdNext = {29'h0, itemSize_reg, halfDuplex_reg};
        else if (haddr == `PDMA_OFF_FLAGS)
        begin
            rdNext[`PDMA_BIT_RX_END]   = fRx_reg[0];
            rdNext[`PDMA_BIT_RX_FULL]  = fRx_reg[1];
            rdNext[`PDMA_BIT_TX_END]   = fRx_reg[2];
            rdNext[`PDMA_BIT_TX_EMPTY] = fRx_reg[3];
        end
    end

    // Read data registered at the address phase; never waits
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else if (addrPhase && !hwrite)
            hrdata <= rdNext;
    end

    // Channel outputs registered
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rxRequest      <= 1'b0;
            txRequest      <= 1'b0;
            rxAddress      <= 32'h00000000;
            txAddress      <= 32'h00000000;
            rxTransferEnd  <= 1'b0;
            rxBuffersFull  <= 1'b0;
            txTransferEnd  <= 1'b0;
            txBuffersEmpty <= 1'b0;
        end
        else
        begin
            rxRequest      <= rxActive && rxEn_reg;
            txRequest      <= halfDuplex_reg ? (rxActive && txEn_reg) : txActive;
            rxAddress      <= rxCurPtr;
            txAddress      <= halfDuplex_reg ? rxCurPtr : txCurPtr;
            rxTransferEnd  <= fRx_reg[0];
            rxBuffersFull  <= fRx_reg[1];
            txTransferEnd  <= fRx_reg[2];
            txBuffersEmpty <= fRx_reg[3];
        end
    end

    AST_RX_DIS: assert property (@(posedge clk) disable iff (!arst_n)
        (ctrlWr && hwdata[`PDMA_BIT_RX_DIS]) |=> !rxEn_reg)
        else $error("receive disable ignored");
    AST_TX_DOM: assert property (@(posedge clk) disable iff (!arst_n)
        (ctrlWr && hwdata[`PDMA_BIT_TX_DIS]) |=> !txEn_reg)
        else $error("transmit disable not dominant");
    AST_HD_EXCL: assert property (@(posedge clk) disable iff (!arst_n)
        (ctrlWr && halfDuplex_reg && hwdata[`PDMA_BIT_RX_EN] && !hwdata[`PDMA_BIT_RX_DIS]
            && !hwdata[`PDMA_BIT_TX_DIS])
        |=> rxEn_reg && !txEn_reg)
        else $error("half duplex receive enable wrong");
    AST_STATUS: assert property (@(posedge clk) disable iff (!arst_n)
        (addrPhase && !hwrite && haddr == `PDMA_OFF_STATUS)
        |=> hrdata == {23'h0, $past(txEn_reg), 7'h0, $past(rxEn_reg)})
        else $error("status readback wrong");
    AST_CNT_HI: assert property (@(posedge clk) disable iff (!arst_n)
        (addrPhase && !hwrite && haddr == `PDMA_OFF_RX_CUR_CNT) |=> hrdata[31:16] == 16'h0000)
        else $error("counter upper bits not zero");
endmodule

// *** pdma_defs.svh ***
// Purpose: Offsets, field positions and reset values of the peripheral DMA channel registers
// Assumes: Included by bare name; definitions only
// Notes:   Byte addresses inside the peripheral's register space
`ifndef PDMA_DEFS_SVH
`define PDMA_DEFS_SVH
`define PDMA_OFF_RX_CUR_PTR   12'h100
`define PDMA_OFF_RX_CUR_CNT   12'h104
`define PDMA_OFF_TX_CUR_PTR   12'h108
`define PDMA_OFF_TX_CUR_CNT   12'h10c
`define PDMA_OFF_RX_NXT_PTR   12'h110
`define PDMA_OFF_RX_NXT_CNT   12'h114
`define PDMA_OFF_TX_NXT_PTR   12'h118
`define PDMA_OFF_TX_NXT_CNT   12'h11c
`define PDMA_OFF_CTRL         12'h120
`define PDMA_OFF_STATUS       12'h124
`define PDMA_OFF_MODE         12'h128
`define PDMA_OFF_FLAGS        12'h12c
`define PDMA_BIT_RX_EN        0
`define PDMA_BIT_RX_DIS       1
`define PDMA_BIT_TX_EN        8
`define PDMA_BIT_TX_DIS       9
`define PDMA_BIT_HALF_DUPLEX  0
`define PDMA_BIT_SIZE_LO      1
`define PDMA_BIT_SIZE_HI      2
`define PDMA_BIT_RX_END       0
`define PDMA_BIT_RX_FULL      1
`define PDMA_BIT_TX_END       8
`define PDMA_BIT_TX_EMPTY     9
`define PDMA_RST_PTR          32'h00000000
`define PDMA_RST_CNT          16'h0000
`endif

// *** pdma_pkg.sv ***
// Purpose: Types shared by the peripheral DMA channel files
// Assumes: Nothing
// Notes:   Item size codes steer the pointer step
package pdma_pkg;
    typedef enum logic [1:0] {PDMA_SZ_BYTE, PDMA_SZ_HALF, PDMA_SZ_WORD} pdma_size_t;
    typedef enum logic [1:0] {PDMA_ST_IDLE, PDMA_ST_WAIT, PDMA_ST_RELOAD} pdma_state_t;
endpackage

// *** pdma_step.sv ***
// Purpose: Byte step of the memory pointer for one item
// Assumes: Size code from the mode register
// Notes:   Unused code steps by one byte
`timescale 1ns/1ps
module pdma_step
    import pdma_pkg::*;
(
    input  wire pdma_pkg::pdma_size_t itemSize,  // Item size
    output logic [2:0]                stepBytes  // Bytes per item
);
    // Byte, half-word or word step
    always_comb
    begin
        case (itemSize)
            PDMA_SZ_HALF: stepBytes = 3'h2;
            PDMA_SZ_WORD: stepBytes = 3'h4;
            default:      stepBytes = 3'h1;
        endcase
    end
endmodule

// *** pdma_dir.sv ***
// Purpose: One direction's pointer and count pair with next-buffer reload
// Assumes: Request pulses come from logic on the same clock
// Notes:   Software writes win over the channel's own update in the same cycle
`timescale 1ns/1ps
`include "pdma_defs.svh"
module pdma_dir
    import pdma_pkg::*;
(
    input  wire logic        clk,        // System clock
    input  wire logic        arst_n,     // Async reset, low
    input  wire logic        enable,     // Channel requests enabled
    input  wire logic        itemDone,   // One item moved
    input  wire logic [2:0]  stepBytes,  // Pointer step
    input  wire logic        wrCurPtr,   // Write current pointer
    input  wire logic        wrCurCnt,   // Write current count
    input  wire logic        wrNxtPtr,   // Write next pointer
    input  wire logic        wrNxtCnt,   // Write next count
    input  wire logic [31:0] wrData,     // Write data
    output logic [31:0]      curPtr,     // Current pointer
    output logic [15:0]      curCnt,     // Current count
    output logic [31:0]      nxtPtr,     // Next pointer
    output logic [15:0]      nxtCnt,     // Next count
    output logic             active,     // Channel may request
    output logic             endSet,     // Current count expired
    output logic             bufSet      // Both counts expired
);
    logic lastItem;
    logic takeNext;
    assign lastItem = itemDone && active && (curCnt == 16'h0001);
    assign takeNext = lastItem && (nxtCnt != 16'h0000);
    // Zero count stops the channel
    assign active = enable && (curCnt != 16'h0000);
    assign endSet = lastItem;
    assign bufSet = lastItem && (nxtCnt == 16'h0000);

    // Current pointer: advance per item, reload from next
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            curPtr <= `PDMA_RST_PTR;
        else if (wrCurPtr)
            curPtr <= wrData;
        else if (takeNext)
            curPtr <= nxtPtr;
        else if (itemDone && active)
            curPtr <= curPtr + {29'h0, stepBytes};
    end

    // Current count: decrement, reload from next
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            curCnt <= `PDMA_RST_CNT;
        else if (wrCurCnt)
            curCnt <= wrData[15:0];
        else if (takeNext)
            curCnt <= nxtCnt;
        else if (itemDone && active)
            curCnt <= curCnt - 16'h0001;
    end

    // Next pair cleared once taken over
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nxtPtr <= `PDMA_RST_PTR;
            nxtCnt <= `PDMA_RST_CNT;
        end
        else
        begin
            if (wrNxtPtr)
                nxtPtr <= wrData;
            else if (takeNext)
                nxtPtr <= 32'h00000000;
            if (wrNxtCnt)
                nxtCnt <= wrData[15:0];
            else if (takeNext)
                nxtCnt <= 16'h0000;
        end
    end

    AST_RELOAD: assert property (@(posedge clk) disable iff (!arst_n)
        (takeNext && !wrCurCnt && !wrNxtCnt) |=> (curCnt == $past(nxtCnt)) && (nxtCnt == 16'h0000))
        else $error("next buffer not taken over");
    AST_STEP: assert property (@(posedge clk) disable iff (!arst_n)
        (itemDone && active && !takeNext && !wrCurPtr) |=> (curPtr == $past(curPtr) + {29'h0, $past(stepBytes)}))
        else $error("pointer step wrong");
    // Item pulses on a stopped channel must not wrap the count
    AST_ZERO_STOP: assert property (@(posedge clk) disable iff (!arst_n)
        (curCnt == 16'h0000 && !wrCurCnt) |=> (curCnt == 16'h0000))
        else $error("zero count moved");
endmodule

// *** pdma_peer_model.sv ***
// Purpose: Far-side model raising item pulses while a channel requests
// Assumes: Shares the system clock with the channel block
// Notes:   Slow mode skips cycles on a pseudo-random pattern
`timescale 1ns/1ps
module pdma_peer_model
(
    input  wire logic clk,         // System clock
    input  wire logic arst_n,      // Async reset, low
    input  wire logic slow,        // Stall on pattern
    input  wire logic rxRequest,   // Receive may move
    input  wire logic txRequest,   // Transmit may move
    output logic      rxItemDone,  // Receive item moved
    output logic      txItemDone   // Transmit item moved
);
    logic [7:0] pat_reg;
    // One-cycle gap after each pulse; the request drops two cycles after the last pulse, so one more pulse can follow it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pat_reg <= 8'h5a;
            rxItemDone <= 1'b0;
            txItemDone <= 1'b0;
        end
        else
        begin
            pat_reg <= {pat_reg[6:0], pat_reg[7] ^ pat_reg[5] ^ pat_reg[4] ^ pat_reg[3]};
            rxItemDone <= rxRequest && !rxItemDone && (!slow || pat_reg[0]);
            txItemDone <= txRequest && !txItemDone && (!slow || pat_reg[1]);
        end
    end
endmodule

// *** tb_pdma_channel_regs.sv ***
// Purpose: Self-checking bench of the channel register block
// Assumes: Zero-wait slave; one item per peer pulse
// Notes:   Random data from a fixed-seed xorshift
`timescale 1ns/1ps
`include "pdma_defs.svh"
module tb_pdma_channel_regs;
    import pdma_pkg::*;
    logic        clk, arst_n, hsel, hwrite, slow, hreadyout, hresp;
    logic        rxItemDone, txItemDone, rxRequest, txRequest, rxEnd, rxFull, txEnd, txEmpty;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rxAddress, txAddress, seed, q;
    int          failCount, numChecks, cycles;
    pdma_channel_regs pdma_channel_regs_i (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxItemDone(rxItemDone),
        .txItemDone(txItemDone), .rxRequest(rxRequest), .txRequest(txRequest), .rxAddress(rxAddress),
        .txAddress(txAddress), .rxTransferEnd(rxEnd), .rxBuffersFull(rxFull), .txTransferEnd(txEnd),
        .txBuffersEmpty(txEmpty));
    pdma_peer_model pdma_peer_model_i (.clk(clk), .arst_n(arst_n), .slow(slow), .rxRequest(rxRequest),
        .txRequest(txRequest), .rxItemDone(rxItemDone), .txItemDone(txItemDone));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] stepOf(input logic [1:0] sz);
        return (sz == 2'h1) ? 32'h2 : (sz == 2'h2) ? 32'h4 : 32'h1;
    endfunction
    // One single transfer; read data taken at the edge ending the data phase
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        numChecks++;
        if (g !== e)
        begin
            failCount++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk(r, e, $sformatf("reg %h", a));
    endtask
    task automatic ctl(input logic [31:0] c, input logic [31:0] e);
        wr(`PDMA_OFF_CTRL, c);
        rdc(`PDMA_OFF_STATUS, e);
    endtask
    // Base 0x100 is receive, 0x108 transmit; next pair sits 0x10 above
    task automatic xfer(input logic [11:0] b, input logic [1:0] sz, input logic [15:0] n, input logic [15:0] m);
        logic [31:0] p, np, e, r, mk;
        p = rnd();
        np = rnd();
        slow <= seed[3];
        mk = b[3] ? 32'h300 : 32'h3;
        e = (m != 16'h0) ? np + m * stepOf(sz) : p + n * stepOf(sz);
        wr(`PDMA_OFF_MODE, {29'h0, sz, 1'b0});
        wr(b, p);
        wr(b + 12'h4, {16'hffff, n});
        wr(b + 12'h10, np);
        wr(b + 12'h14, {16'h0, m});
        wr(`PDMA_OFF_CTRL, b[3] ? 32'h100 : 32'h1);
        r = 32'h1;
        for (int k = 0; k < 300 && r !== 32'h0; k++) bus(b + 12'h4, 1'b0, 32'h0, r);
        chk(r, 32'h0, "count");
        rdc(b, e);
        rdc(b + 12'h14, 32'h0);
        chk(b[3] ? txAddress : rxAddress, e, "address");
        chk(32'(b[3] ? txRequest : rxRequest), 32'h0, "request");
        bus(`PDMA_OFF_FLAGS, 1'b0, 32'h0, r);
        chk(r & mk, mk, "flags");
        chk(32'(b[3] ? {txEmpty, txEnd} : {rxFull, rxEnd}), 32'h3, "flag pins");
        ctl(b[3] ? 32'h200 : 32'h2, 32'h0);
        $display("test transfer %h done", b);
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Run should end well before this ceiling
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failCount++;
            finalReport();
        end
    end
    initial
    begin
        seed = 32'h00017ba4;
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        slow = 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 'h100; a <= 'h130; a += 4) rdc(12'(a), 32'h0);
        q = rnd();
        wr(`PDMA_OFF_RX_NXT_PTR, q);
        rdc(`PDMA_OFF_RX_NXT_PTR, q);
        wr(`PDMA_OFF_TX_NXT_CNT, 32'hffff1234);
        rdc(`PDMA_OFF_TX_NXT_CNT, 32'h1234);
        wr(`PDMA_OFF_TX_NXT_CNT, 32'h0);
        chk(32'(hresp), 32'h0, "response");
        $display("test registers done");
        ctl(32'h3, 32'h0);
        ctl(32'h1, 32'h1);
        ctl(32'h0, 32'h1);
        ctl(32'h301, 32'h1);
        ctl(32'h100, 32'h101);
        ctl(32'h200, 32'h1);
        ctl(32'h2, 32'h0);
        wr(`PDMA_OFF_MODE, 32'h1);
        ctl(32'h100, 32'h100);
        ctl(32'h1, 32'h1);
        ctl(32'h200, 32'h0);
        ctl(32'h100, 32'h100);
        ctl(32'h200, 32'h0);
        ctl(32'h100, 32'h100);
        ctl(32'h2, 32'h0);
        q = rnd();
        wr(`PDMA_OFF_TX_CUR_PTR, q);
        rdc(`PDMA_OFF_RX_CUR_PTR, q);
        chk(txAddress, q, "shared address");
        wr(`PDMA_OFF_RX_NXT_CNT, 32'h5);
        rdc(`PDMA_OFF_TX_NXT_CNT, 32'h5);
        wr(`PDMA_OFF_RX_NXT_CNT, 32'h0);
        $display("test control done");
        xfer(12'h100, 2'h2, 16'(rnd() % 8 + 1), 16'(rnd() % 4 + 1));
        for (int s = 0; s < 4; s++) xfer(12'h108, 2'(s), 16'(rnd() % 8 + 1), 16'(s));
        finalReport();
    end
endmodule
